// >>> hdl/hdbc_top.sv
// Register bank and eight half-bridge sequencers for dead time and blanking selection
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/100ps

module hdbc_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Pair 3 blanking and pair 4 dead and blanking codes held elsewhere
  input  wire logic [8:0]  act_ext_pair34,
  input  wire logic [8:0]  fw_ext_pair34,
  // Half-bridge control
  input  wire logic [15:0] hb_mode_req,
  input  wire logic [7:0]  hs_is_active,
  input  wire logic [7:0]  vds_raw,
  // Gate and fault outputs
  output logic [7:0]       hs_gate_on,
  output logic [7:0]       ls_gate_on,
  output logic [7:0]       vds_fault
);

  logic                    rst_meta_r;
  logic                    rst_q_r;
  logic [15:0]             pair_map_r;
  logic [14:0]             act_timing_r;
  logic [14:0]             fw_timing_r;
  logic                    bank_r;
  logic                    wait_r;
  logic [31:0]             rdata_r;
  logic [5:0]              idx;
  logic                    wr_take;
  logic                    rd_start;
  logic [15:0]             wr_mask;
  logic [15:0]             wr_word;
  logic [31:0]             rd_nxt;
  logic [2:0]              sel_act_dead [8];
  logic [2:0]              sel_act_blank [8];
  logic [2:0]              sel_fw_dead [8];
  logic [2:0]              sel_fw_blank [8];

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------

  // Release the asynchronous reset through two flip-flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_q_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_q_r    <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------

  // Word index, write acceptance and byte-lane mask
  assign idx      = avs_address[7:2];
  assign wr_take  = avs_write && !wait_r;
  assign rd_start = avs_read && wait_r;
  assign wr_mask  = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_word  = avs_writedata[15:0];

  // One wait state, then the answer for exactly one cycle
  always_ff @(posedge mclk or negedge rst_q_r) begin
    if (!rst_q_r) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !((avs_read || avs_write) && wait_r);
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------

  // Pair map, one 2-bit selector per half-bridge
  always_ff @(posedge mclk or negedge rst_q_r) begin
    if (!rst_q_r) begin
      pair_map_r <= hdbc_pkg::PAIR_MAP_RST;
    end else if (wr_take && idx == hdbc_pkg::IDX_PAIR_MAP) begin
      pair_map_r <= (pair_map_r & ~wr_mask) | (wr_word & wr_mask);
    end
  end

  // Active and freewheeling timing sets share one offset, split by bank
  always_ff @(posedge mclk or negedge rst_q_r) begin
    if (!rst_q_r) begin
      act_timing_r <= hdbc_pkg::TIMING_RST;
      fw_timing_r  <= hdbc_pkg::TIMING_RST;
    end else if (wr_take && idx == hdbc_pkg::IDX_TIMING) begin
      if (bank_r == hdbc_pkg::BANK_ACTIVE) begin
        act_timing_r <= (act_timing_r & ~wr_mask[14:0]) | (wr_word[14:0] & wr_mask[14:0]);
      end else begin
        fw_timing_r <= (fw_timing_r & ~wr_mask[14:0]) | (wr_word[14:0] & wr_mask[14:0]);
      end
    end
  end

  // Register bank select
  always_ff @(posedge mclk or negedge rst_q_r) begin
    if (!rst_q_r) begin
      bank_r <= hdbc_pkg::BANK_RST;
    end else if (wr_take && idx == hdbc_pkg::IDX_BANK && avs_byteenable[0]) begin
      bank_r <= avs_writedata[0];
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------

  // Read mux; reserved and unmapped bits read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (idx)
      hdbc_pkg::IDX_PAIR_MAP: rd_nxt = {16'h0000, pair_map_r};
      hdbc_pkg::IDX_TIMING: begin
        if (bank_r == hdbc_pkg::BANK_ACTIVE) begin
          rd_nxt = {17'h00000, act_timing_r};
        end else begin
          rd_nxt = {17'h00000, fw_timing_r};
        end
      end
      hdbc_pkg::IDX_BANK:   rd_nxt = {31'h0000_0000, bank_r};
      hdbc_pkg::IDX_STATUS: rd_nxt = {8'h00, vds_fault, ls_gate_on, hs_gate_on};
      default:              rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data captured with the answer and held until the next read
  always_ff @(posedge mclk or negedge rst_q_r) begin
    if (!rst_q_r) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_start) begin
      rdata_r <= rd_nxt;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;

  // ----------------------------------------------------------------
  // Half-bridge sequencers
  // ----------------------------------------------------------------

  genvar n;
  generate
    for (n = 0; n < 8; n = n + 1) begin : g_hb
      // Pick the dead and blanking codes of the mapped pair for both sets
      always_comb begin
        unique case (pair_map_r[2*n +: hdbc_pkg::SEL_W])
          2'b00: begin
            sel_act_dead[n]  = act_timing_r[hdbc_pkg::DEAD1_LSB +: hdbc_pkg::CODE_W];
            sel_act_blank[n] = act_timing_r[hdbc_pkg::BLANK1_LSB +: hdbc_pkg::CODE_W];
            sel_fw_dead[n]   = fw_timing_r[hdbc_pkg::DEAD1_LSB +: hdbc_pkg::CODE_W];
            sel_fw_blank[n]  = fw_timing_r[hdbc_pkg::BLANK1_LSB +: hdbc_pkg::CODE_W];
          end
          2'b01: begin
            sel_act_dead[n]  = act_timing_r[hdbc_pkg::DEAD2_LSB +: hdbc_pkg::CODE_W];
            sel_act_blank[n] = act_timing_r[hdbc_pkg::BLANK2_LSB +: hdbc_pkg::CODE_W];
            sel_fw_dead[n]   = fw_timing_r[hdbc_pkg::DEAD2_LSB +: hdbc_pkg::CODE_W];
            sel_fw_blank[n]  = fw_timing_r[hdbc_pkg::BLANK2_LSB +: hdbc_pkg::CODE_W];
          end
          2'b10: begin
            sel_act_dead[n]  = act_timing_r[hdbc_pkg::DEAD3_LSB +: hdbc_pkg::CODE_W];
            sel_act_blank[n] = act_ext_pair34[hdbc_pkg::EXT_BLANK3_LSB +: hdbc_pkg::CODE_W];
            sel_fw_dead[n]   = fw_timing_r[hdbc_pkg::DEAD3_LSB +: hdbc_pkg::CODE_W];
            sel_fw_blank[n]  = fw_ext_pair34[hdbc_pkg::EXT_BLANK3_LSB +: hdbc_pkg::CODE_W];
          end
          2'b11: begin
            sel_act_dead[n]  = act_ext_pair34[hdbc_pkg::EXT_DEAD4_LSB +: hdbc_pkg::CODE_W];
            sel_act_blank[n] = act_ext_pair34[hdbc_pkg::EXT_BLANK4_LSB +: hdbc_pkg::CODE_W];
            sel_fw_dead[n]   = fw_ext_pair34[hdbc_pkg::EXT_DEAD4_LSB +: hdbc_pkg::CODE_W];
            sel_fw_blank[n]  = fw_ext_pair34[hdbc_pkg::EXT_BLANK4_LSB +: hdbc_pkg::CODE_W];
          end
        endcase
      end

      hdbc_bridge u_bridge (
        .mclk         (mclk),
        .rst_q_b      (rst_q_r),
        .mode_req     (hb_mode_req[2*n +: 2]),
        .hs_is_active (hs_is_active[n]),
        .vds_raw      (vds_raw[n]),
        .act_dead     (sel_act_dead[n]),
        .act_blank    (sel_act_blank[n]),
        .fw_dead      (sel_fw_dead[n]),
        .fw_blank     (sel_fw_blank[n]),
        .hs_on_r      (hs_gate_on[n]),
        .ls_on_r      (ls_gate_on[n]),
        .vds_fault_r  (vds_fault[n])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_map_reset;
    @(posedge mclk) disable iff (!rst_q_r) $rose(rst_q_r) |-> (pair_map_r == 16'h0000);
  endproperty
  a_map_reset: assert property (p_map_reset)
    else $error("Pair map not zero after reset");

  property p_timing_reset;
    @(posedge mclk) disable iff (!rst_q_r)
      $rose(rst_q_r) |-> (act_timing_r == 15'h4924 && fw_timing_r == 15'h4924);
  endproperty
  a_timing_reset: assert property (p_timing_reset)
    else $error("Timing sets not at 0x4924 after reset");

  property p_rsvd_zero;
    @(posedge mclk) disable iff (!rst_q_r)
      (avs_read && !wait_r && $past(idx) == hdbc_pkg::IDX_TIMING) |-> !avs_readdata[15];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("Reserved timing bit read as one");

  property p_bank0_write;
    @(posedge mclk) disable iff (!rst_q_r)
      (wr_take && idx == hdbc_pkg::IDX_TIMING && !bank_r && avs_byteenable[1:0] == 2'h3)
        |=> (act_timing_r == $past(avs_writedata[14:0])) && $stable(fw_timing_r);
  endproperty
  a_bank0_write: assert property (p_bank0_write)
    else $error("Bank 0 timing write misrouted");

  property p_bank1_write;
    @(posedge mclk) disable iff (!rst_q_r)
      (wr_take && idx == hdbc_pkg::IDX_TIMING && bank_r && avs_byteenable[1:0] == 2'h3)
        |=> (fw_timing_r == $past(avs_writedata[14:0])) && $stable(act_timing_r);
  endproperty
  a_bank1_write: assert property (p_bank1_write)
    else $error("Bank 1 timing write misrouted");

  property p_hb8_pair;
    @(posedge mclk) disable iff (!rst_q_r)
      (pair_map_r[15:14] == 2'b11) |-> (sel_act_dead[7] == act_ext_pair34[5:3]);
  endproperty
  a_hb8_pair: assert property (p_hb8_pair)
    else $error("Half-bridge 8 not on pair 4 dead time");

  property p_hb1_pair;
    @(posedge mclk) disable iff (!rst_q_r)
      (pair_map_r[1:0] == 2'b00) |-> (sel_fw_blank[0] == fw_timing_r[5:3]);
  endproperty
  a_hb1_pair: assert property (p_hb1_pair)
    else $error("Half-bridge 1 not on pair 1 blanking time");

  property p_answer;
    @(posedge mclk) disable iff (!rst_q_r)
      ((avs_read || avs_write) && wait_r) |=> !wait_r ##1 wait_r;
  endproperty
  a_answer: assert property (p_answer)
    else $error("Bus answer not given after one wait state");

endmodule // hdbc_top

// >>> hdl/hdbc_pkg.sv
// Shared constants, types and timing lookups for the dead time and blanking configuration block
package hdbc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_PAIR_MAP    = 6'h04;
  localparam logic [5:0] IDX_TIMING      = 6'h05;
  localparam logic [5:0] IDX_BANK        = 6'h10;
  localparam logic [5:0] IDX_STATUS      = 6'h11;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [15:0] PAIR_MAP_RST   = 16'h0000;
  localparam logic [14:0] TIMING_RST     = 15'h4924;
  localparam logic        BANK_RST       = 1'b0;
  localparam logic        BANK_ACTIVE    = 1'b0;
  localparam logic        BANK_FREEWHEEL = 1'b1;
  localparam int          SEL_W          = 2;
  localparam int          CODE_W         = 3;
  localparam int          DEAD1_LSB      = 0;
  localparam int          BLANK1_LSB     = 3;
  localparam int          DEAD2_LSB      = 6;
  localparam int          BLANK2_LSB     = 9;
  localparam int          DEAD3_LSB      = 12;
  localparam int          RSVD_BIT       = 15;
  // External pair 3 and 4 codes: blank3, dead4, blank4
  localparam int          EXT_BLANK3_LSB = 0;
  localparam int          EXT_DEAD4_LSB  = 3;
  localparam int          EXT_BLANK4_LSB = 6;

  // ----------------------------------------------------------------
  // Half-bridge request codes
  // ----------------------------------------------------------------
  localparam logic [1:0] REQ_LS_ON       = 2'b01;
  localparam logic [1:0] REQ_HS_ON       = 2'b10;

  // ----------------------------------------------------------------
  // Timing: printed times in ns, counts at 40 MHz (rounded up)
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_375_NS      = 375;
  localparam int T_625_NS      = 625;
  localparam int T_1000_NS     = 1000;
  localparam int T_1250_NS     = 1250;
  localparam int T_1500_NS     = 1500;
  localparam int T_2000_NS     = 2000;
  localparam int T_3000_NS     = 3000;
  localparam int T_4000_NS     = 4000;
  localparam int T_16000_NS    = 16000;
  localparam int CNT_W         = 10;

  localparam logic [CNT_W-1:0] CYC_375   = CNT_W'((T_375_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CYC_625   = CNT_W'((T_625_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CYC_1000  = CNT_W'((T_1000_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CYC_1250  = CNT_W'((T_1250_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CYC_1500  = CNT_W'((T_1500_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CYC_2000  = CNT_W'((T_2000_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CYC_3000  = CNT_W'((T_3000_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CYC_4000  = CNT_W'((T_4000_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CYC_16000 = CNT_W'((T_16000_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Dead time code to cycles
  function automatic logic [CNT_W-1:0] dead_cycles(input logic [CODE_W-1:0] code);
    unique case (code)
      3'h0: dead_cycles = CYC_375;
      3'h1: dead_cycles = CYC_625;
      3'h2: dead_cycles = CYC_1000;
      3'h3: dead_cycles = CYC_1500;
      3'h4: dead_cycles = CYC_2000;
      3'h5: dead_cycles = CYC_3000;
      3'h6: dead_cycles = CYC_4000;
      3'h7: dead_cycles = CYC_16000;
    endcase
  endfunction

  // Blanking time code to cycles
  function automatic logic [CNT_W-1:0] blank_cycles(input logic [CODE_W-1:0] code);
    unique case (code)
      3'h0: blank_cycles = CYC_625;
      3'h1: blank_cycles = CYC_1000;
      3'h2: blank_cycles = CYC_1250;
      3'h3: blank_cycles = CYC_1500;
      3'h4: blank_cycles = CYC_2000;
      3'h5: blank_cycles = CYC_3000;
      3'h6: blank_cycles = CYC_4000;
      3'h7: blank_cycles = CYC_16000;
    endcase
  endfunction

  // Per half-bridge switching states
  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_DEAD  = 2'b01,
    ST_DRIVE = 2'b10
  } hdbc_state_type;

endpackage

// >>> hdl/hdbc_bridge.sv
// One half-bridge switching sequencer with dead time and drain-source blanking
`timescale 1ns/100ps
module hdbc_bridge (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_q_b,
  // Request and monitor
  input  wire logic [1:0] mode_req,
  input  wire logic       hs_is_active,
  input  wire logic       vds_raw,
  // Selected timing codes
  input  wire logic [2:0] act_dead,
  input  wire logic [2:0] act_blank,
  input  wire logic [2:0] fw_dead,
  input  wire logic [2:0] fw_blank,
  // Gate and fault outputs
  output logic            hs_on_r,
  output logic            ls_on_r,
  output logic            vds_fault_r
);

  hdbc_pkg::hdbc_state_type        state_r;
  logic                            tgt_hs_r;
  logic [hdbc_pkg::CNT_W-1:0]      dead_cnt_r;
  logic [hdbc_pkg::CNT_W-1:0]      blank_cnt_r;
  logic                            want_hs;
  logic                            want_on;
  logic                            new_is_act;
  logic                            cur_is_act;
  logic [hdbc_pkg::CNT_W-1:0]      dead_load;
  logic [hdbc_pkg::CNT_W-1:0]      blank_load;
  logic                            go_drive;
  logic                            go_off;
  logic                            sw_evt;

  // Request decode and timing set selection, active or freewheeling
  assign want_hs    = (mode_req == hdbc_pkg::REQ_HS_ON);
  assign want_on    = want_hs | (mode_req == hdbc_pkg::REQ_LS_ON);
  assign new_is_act = want_hs ? hs_is_active : ~hs_is_active;
  assign cur_is_act = tgt_hs_r ? hs_is_active : ~hs_is_active;
  assign dead_load  = hdbc_pkg::dead_cycles(new_is_act ? act_dead : fw_dead) - 10'h001;
  assign blank_load = hdbc_pkg::blank_cycles(cur_is_act ? act_blank : fw_blank) - 10'h001;
  assign go_drive   = (state_r == hdbc_pkg::ST_DEAD) && want_on && (want_hs == tgt_hs_r)
                      && (dead_cnt_r == 10'h000);
  assign go_off     = (state_r == hdbc_pkg::ST_DRIVE) && (!want_on || (want_hs != tgt_hs_r));
  assign sw_evt     = go_drive | go_off;

  // Switching sequence: both gates off through the dead time before turn-on
  always_ff @(posedge mclk or negedge rst_q_b) begin
    if (!rst_q_b) begin
      state_r    <= hdbc_pkg::ST_OFF;
      tgt_hs_r   <= 1'b0;
      dead_cnt_r <= 10'h000;
      hs_on_r    <= 1'b0;
      ls_on_r    <= 1'b0;
    end else begin
      unique case (state_r)
        hdbc_pkg::ST_OFF: begin
          if (want_on) begin
            state_r    <= hdbc_pkg::ST_DEAD;
            tgt_hs_r   <= want_hs;
            dead_cnt_r <= dead_load;
          end
        end
        hdbc_pkg::ST_DEAD: begin
          if (!want_on) begin
            state_r <= hdbc_pkg::ST_OFF;
          end else if (want_hs != tgt_hs_r) begin
            tgt_hs_r   <= want_hs;
            dead_cnt_r <= dead_load;
          end else if (go_drive) begin
            state_r <= hdbc_pkg::ST_DRIVE;
            hs_on_r <= tgt_hs_r;
            ls_on_r <= ~tgt_hs_r;
          end else begin
            dead_cnt_r <= dead_cnt_r - 10'h001;
          end
        end
        hdbc_pkg::ST_DRIVE: begin
          if (go_off) begin
            hs_on_r <= 1'b0;
            ls_on_r <= 1'b0;
            if (!want_on) begin
              state_r <= hdbc_pkg::ST_OFF;
            end else begin
              state_r    <= hdbc_pkg::ST_DEAD;
              tgt_hs_r   <= want_hs;
              dead_cnt_r <= dead_load;
            end
          end
        end
        default: begin
          state_r <= hdbc_pkg::ST_OFF;
          hs_on_r <= 1'b0;
          ls_on_r <= 1'b0;
        end
      endcase
    end
  end

  // Blanking counter restarted on every gate edge
  always_ff @(posedge mclk or negedge rst_q_b) begin
    if (!rst_q_b) begin
      blank_cnt_r <= 10'h000;
    end else if (sw_evt) begin
      blank_cnt_r <= blank_load;
    end else if (blank_cnt_r != 10'h000) begin
      blank_cnt_r <= blank_cnt_r - 10'h001;
    end
  end

  // Drain-source fault passes only outside the blanking window
  always_ff @(posedge mclk or negedge rst_q_b) begin
    if (!rst_q_b) begin
      vds_fault_r <= 1'b0;
    end else begin
      vds_fault_r <= vds_raw && (blank_cnt_r == 10'h000) && !sw_evt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_never_both;
    @(posedge mclk) disable iff (!rst_q_b) !(hs_on_r && ls_on_r);
  endproperty
  a_never_both: assert property (p_never_both)
    else $error("Both gates of a half-bridge are on");

  property p_min_dead;
    @(posedge mclk) disable iff (!rst_q_b)
      $rose(hs_on_r) |-> $past(!hs_on_r && !ls_on_r, 15);
  endproperty
  a_min_dead: assert property (p_min_dead)
    else $error("High-side turned on without a full dead time");

  property p_blank_mask;
    @(posedge mclk) disable iff (!rst_q_b)
      (blank_cnt_r != 10'h000) |=> !vds_fault_r;
  endproperty
  a_blank_mask: assert property (p_blank_mask)
    else $error("Drain-source fault passed during blanking");

  property p_blank_start;
    @(posedge mclk) disable iff (!rst_q_b)
      ($changed(hs_on_r) || $changed(ls_on_r)) |-> (blank_cnt_r != 10'h000);
  endproperty
  a_blank_start: assert property (p_blank_start)
    else $error("Blanking not started on a gate edge");

endmodule // hdbc_bridge

// >>> verification/half_bridge_deadtime_blank_config_bench.sv
// Self-checking bench for the dead time and blanking configuration block
`timescale 1ns/100ps
module half_bridge_deadtime_blank_config_bench;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        mclk = 0, rst_b = 1, avs_read = 0, avs_write = 0;
  logic [7:0]  avs_address = 8'h00, hs_is_active = 8'h01, vds_raw = 8'h00;
  logic [3:0]  avs_byteenable = 4'h3;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [8:0]  act_ext_pair34 = 9'h018, fw_ext_pair34 = 9'h1ff;
  logic [15:0] hb_mode_req = 16'h0000;
  logic [7:0]  hs_gate_on, ls_gate_on, vds_fault;
  logic        avs_waitrequest;
  int          miscompares = 0, comparisons = 0;
  int          dt[8] = '{375, 625, 1000, 1500, 2000, 3000, 4000, 16000};
  int          bt[8] = '{625, 1000, 1250, 1500, 2000, 3000, 4000, 16000};
  hdbc_top hdbc_top_inst (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .act_ext_pair34(act_ext_pair34),
    .fw_ext_pair34(fw_ext_pair34), .hb_mode_req(hb_mode_req), .hs_is_active(hs_is_active),
    .vds_raw(vds_raw), .hs_gate_on(hs_gate_on), .ls_gate_on(ls_gate_on), .vds_fault(vds_fault));
  // 40 MHz clock
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Turn one gate on and count edges until it rises; other gate must be off at that edge
  task automatic sw(input int b, input logic [1:0] r, input int d);
    int n;
    n = 0;
    @(posedge mclk) hb_mode_req[2*b+:2] <= r;
    do begin
      @(posedge mclk);
      #1 n++;
    end while ((r == 2'b10 ? hs_gate_on[b] : ls_gate_on[b]) !== 1'b1 && n < 2000);
    chk(n >= (d + 24) / 25 && n <= (d + 24) / 25 + 1, 1);
    chk(r == 2'b10 ? ls_gate_on[b] : hs_gate_on[b], 0);
  endtask
  task automatic off(input int b);
    @(posedge mclk) hb_mode_req[2*b+:2] <= 2'b00;
    repeat (3) @(posedge mclk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    bus(0, 8'h10, 0); chk(q, 32'h0000);
    bus(0, 8'h14, 0); chk(q, 32'h4924);
    bus(0, 8'h3c, 0); chk(q, 32'h0000);
    bus(1, 8'h14, 16'hffff); bus(0, 8'h14, 0); chk(q, 32'h7fff);
  endtask
  // Every dead and blanking code through pair 1 of bridge 1
  // Code 7 assumes software holds the drive current under 30 mA elsewhere
  task automatic t_codes();
    for (int k = 0; k < 8; k++) begin
      bus(1, 8'h14, 16'(k * 9));
      sw(0, 2'b10, dt[k]);
      @(posedge mclk) vds_raw[0] <= 1'b1;
      repeat ((bt[k] + 24) / 25 - 3) @(posedge mclk);
      #1 chk(vds_fault[0], 0);
      repeat (5) @(posedge mclk);
      #1 chk(vds_fault[0], 1);
      @(posedge mclk) vds_raw[0] <= 1'b0;
      off(0);
    end
  endtask
  // Pair selection per bridge, bank routing and freewheel set
  task automatic t_map();
    bus(1, 8'h10, 16'hc001); bus(0, 8'h10, 0); chk(q, 32'hc001);
    bus(1, 8'h14, 16'h0080);
    bus(1, 8'h40, 16'h0001); bus(1, 8'h14, 16'h0140);
    bus(0, 8'h14, 0); chk(q, 32'h0140);
    bus(1, 8'h40, 16'h0000); bus(0, 8'h14, 0); chk(q, 32'h0080);
    sw(0, 2'b10, 1000); off(0);
    @(posedge mclk) hs_is_active <= 8'h00;
    sw(0, 2'b10, 3000); off(0);
    sw(7, 2'b01, 1500); off(7);
  endtask
  // Side change while driving, mode 11, then a reset in mid-run
  task automatic t_reset();
    sw(0, 2'b10, 3000);
    sw(0, 2'b01, 1000);
    @(posedge mclk) hb_mode_req[1:0] <= 2'b11;
    repeat (2) @(posedge mclk);
    #1 chk({hs_gate_on[0], ls_gate_on[0]}, 0);
    @(posedge mclk) rst_b <= 1'b0;
    hb_mode_req[1:0] <= 2'b00;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    bus(0, 8'h10, 0); chk(q, 32'h0000);
    bus(0, 8'h14, 0); chk(q, 32'h4924);
  endtask
  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    miscompares++;
    summarize();
  end
  initial begin
    rst_b <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    t_regs();
    t_codes();
    t_map();
    t_reset();
    summarize();
  end
endmodule // half_bridge_deadtime_blank_config_bench
